/* File: rtl/ecpt_defines.vh */
`ifndef ECPT_DEFINES_VH
`define ECPT_DEFINES_VH

// ****************************************************************
// Register addresses on the special-function-register bus
// ****************************************************************
`define ECPT_ADDR_CFG     8'hA9
`define ECPT_ADDR_ENABLE  8'hAA
`define ECPT_ADDR_LDPOL   8'hAB
`define ECPT_ADDR_DATA    8'hAC

// ****************************************************************
// Field positions of channel_access_config
// ****************************************************************
`define ECPT_CFG_HOLD     6
`define ECPT_CFG_CLEAR    5
`define ECPT_CFG_HIGH     4
`define ECPT_CFG_END      3
`define ECPT_CFG_CH_MSB   2
`define ECPT_CFG_CH_LSB   0

// ****************************************************************
// Reset values and counter constants
// ****************************************************************
`define ECPT_RST_BYTE     8'h00
`define ECPT_RST_WORD     16'h0000
`define ECPT_CNT_ZERO     16'h0000
`define ECPT_CNT_STEP     16'h0001

`endif

/* File: rtl/ecpt_shadow.v */
`include "ecpt_defines.vh"

// ****************************************************************
// Shadow copy of one channel's toggle point and period limit
// ****************************************************************
module ecpt_shadow #(
  parameter WIDTH = 16
) (
  input  wire             clock,
  input  wire             arst_n,
  input  wire             wr_byte,
  input  wire             sel_end,
  input  wire             sel_high,
  input  wire [7:0]       wdata,
  output reg  [WIDTH-1:0] shadow_mid,
  output reg  [WIDTH-1:0] shadow_end
);

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      shadow_mid <= `ECPT_RST_WORD;
      shadow_end <= `ECPT_RST_WORD;
    end else if (wr_byte) begin
      // Byte lands only in the shadow, never in the active value
      if (sel_end) begin
        if (sel_high) begin
          shadow_end[15:8] <= wdata;
        end else begin
          shadow_end[7:0] <= wdata;
        end
      end else begin
        if (sel_high) begin
          shadow_mid[15:8] <= wdata;
        end else begin
          shadow_mid[7:0] <= wdata;
        end
      end
    end
  end

endmodule

/* File: rtl/ecpt_load_flag.v */
`include "ecpt_defines.vh"

// ****************************************************************
// Load-pending flag of one channel
// ****************************************************************
module ecpt_load_flag (
  input  wire clock,
  input  wire arst_n,
  input  wire touch,
  input  wire loaded,
  input  wire clear_all,
  output reg  pending
);

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pending <= 1'b0;
    end else if (touch) begin
      // A new write wins over a load or clear in the same cycle
      pending <= 1'b1;
    end else if (loaded || clear_all) begin
      pending <= 1'b0;
    end
  end

endmodule

/* File: rtl/ecpt_timer.v */
`include "ecpt_defines.vh"

module ecpt_timer #(
  parameter CHANNELS = 8,
  parameter WIDTH    = 16
) (
  input  wire                clock,
  input  wire                arst_n,
  input  wire [7:0]          sfr_addr,
  input  wire [7:0]          sfr_wdata,
  input  wire                sfr_wr,
  input  wire                sfr_rd,
  input  wire [CHANNELS-1:0] timer_mode,
  input  wire [CHANNELS-1:0] count_tick,
  output reg  [7:0]          sfr_rdata,
  output reg  [CHANNELS-1:0] pwm_out,
  output reg  [CHANNELS-1:0] wrap_pulse
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function [7:0] pick_byte;
    input [WIDTH-1:0] word;
    input             high;
    begin
      pick_byte = high ? word[15:8] : word[7:0];
    end
  endfunction

  function [WIDTH-1:0] pick_word;
    input [CHANNELS*WIDTH-1:0] flat;
    input [2:0]                idx;
    begin
      pick_word = flat[idx*WIDTH +: WIDTH];
    end
  endfunction

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire wr_cfg   = sfr_wr && (sfr_addr == `ECPT_ADDR_CFG);
  wire wr_en    = sfr_wr && (sfr_addr == `ECPT_ADDR_ENABLE);
  wire wr_ldpol = sfr_wr && (sfr_addr == `ECPT_ADDR_LDPOL);
  wire wr_data  = sfr_wr && (sfr_addr == `ECPT_ADDR_DATA);

  // ****************************************************************
  // Configuration and enable registers
  // ****************************************************************
  reg                update_hold;
  reg                byte_half_select;
  reg                value_type_select;
  reg [2:0]          channel_select;
  reg                clear_all_strobe;
  reg [CHANNELS-1:0] channel_enable;
  reg [CHANNELS-1:0] pol_shadow;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      update_hold       <= 1'b0;
      byte_half_select  <= 1'b0;
      value_type_select <= 1'b0;
      channel_select    <= 3'h0;
      clear_all_strobe  <= 1'b0;
    end else begin
      clear_all_strobe <= wr_cfg && sfr_wdata[`ECPT_CFG_CLEAR];
      if (wr_cfg) begin
        update_hold       <= sfr_wdata[`ECPT_CFG_HOLD];
        byte_half_select  <= sfr_wdata[`ECPT_CFG_HIGH];
        value_type_select <= sfr_wdata[`ECPT_CFG_END];
        channel_select    <= sfr_wdata[`ECPT_CFG_CH_MSB:`ECPT_CFG_CH_LSB];
      end
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      channel_enable <= `ECPT_RST_BYTE;
    end else if (wr_en) begin
      channel_enable <= sfr_wdata;
    end
  end

  // Polarity writes in pulse mode go to the shadow start level
  integer p;
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pol_shadow <= `ECPT_RST_BYTE;
    end else if (wr_ldpol) begin
      for (p = 0; p < CHANNELS; p = p + 1) begin
        if (!timer_mode[p]) begin
          pol_shadow[p] <= sfr_wdata[p];
        end
      end
    end
  end

  // ****************************************************************
  // Per-channel shadows, load flags and counters
  // ****************************************************************
  wire [CHANNELS*WIDTH-1:0] shadow_mid_all;
  wire [CHANNELS*WIDTH-1:0] shadow_end_all;
  wire [CHANNELS-1:0]       pending;

  genvar i;
  generate
    for (i = 0; i < CHANNELS; i = i + 1) begin : g_ch
      wire             sel_me   = ({29'h0, channel_select} == i);
      wire             wr_byte  = wr_data && sel_me;
      wire             pol_wr   = wr_ldpol && !timer_mode[i];
      wire             clr_wr   = wr_ldpol && timer_mode[i] && sfr_wdata[i];
      wire [WIDTH-1:0] smid     = shadow_mid_all[i*WIDTH +: WIDTH];
      wire [WIDTH-1:0] send     = shadow_end_all[i*WIDTH +: WIDTH];
      reg  [WIDTH-1:0] count;
      reg  [WIDTH-1:0] mid_act;
      reg  [WIDTH-1:0] end_act;
      reg              pol_act;
      wire             step     = channel_enable[i] && count_tick[i];
      wire             at_end   = (count == end_act);
      wire             cyc_end  = step && at_end;
      // Disabled channels have no cycle, so they take settings at once unless update_hold is set
      wire             load_now = !update_hold && pending[i] &&
                                  (cyc_end || !channel_enable[i]);
      wire [WIDTH-1:0] next_count = count + `ECPT_CNT_STEP;

      ecpt_shadow #(
        .WIDTH (WIDTH)
      ) u_shadow (
        .clock      (clock),
        .arst_n     (arst_n),
        .wr_byte    (wr_byte),
        .sel_end    (value_type_select),
        .sel_high   (byte_half_select),
        .wdata      (sfr_wdata),
        .shadow_mid (shadow_mid_all[i*WIDTH +: WIDTH]),
        .shadow_end (shadow_end_all[i*WIDTH +: WIDTH])
      );

      ecpt_load_flag u_flag (
        .clock     (clock),
        .arst_n    (arst_n),
        .touch     (wr_byte || pol_wr),
        .loaded    (load_now),
        .clear_all (clear_all_strobe),
        .pending   (pending[i])
      );

      // Active values change only at the load point
      always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          mid_act <= `ECPT_RST_WORD;
          end_act <= `ECPT_RST_WORD;
          pol_act <= 1'b0;
        end else if (load_now) begin
          mid_act <= smid;
          end_act <= send;
          pol_act <= pol_shadow[i];
        end
      end

      // Counter, output level and wrap event
      always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          count         <= `ECPT_CNT_ZERO;
          pwm_out[i]    <= 1'b0;
          wrap_pulse[i] <= 1'b0;
        end else begin
          // A cleared counter has not wrapped, so no wrap event
          wrap_pulse[i] <= cyc_end && !(clear_all_strobe || clr_wr);
          if (!channel_enable[i]) begin
            count      <= `ECPT_CNT_ZERO;
            pwm_out[i] <= 1'b0;
          end else if (clear_all_strobe || clr_wr) begin
            count <= `ECPT_CNT_ZERO;
            if (!timer_mode[i]) begin
              pwm_out[i] <= pol_act;
            end
          end else if (step) begin
            if (at_end) begin
              count <= `ECPT_CNT_ZERO;
              if (timer_mode[i]) begin
                pwm_out[i] <= !pwm_out[i];
              end else begin
                pwm_out[i] <= load_now ? pol_shadow[i] : pol_act;
              end
            end else begin
              count <= next_count;
              if (!timer_mode[i] && (next_count == mid_act)) begin
                pwm_out[i] <= !pol_act;
              end
            end
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read path
  // ****************************************************************
  reg [7:0]       next_rdata;
  reg [WIDTH-1:0] sel_word;

  always @* begin
    sel_word = value_type_select ? pick_word(shadow_end_all, channel_select)
                                 : pick_word(shadow_mid_all, channel_select);
    case (sfr_addr)
      `ECPT_ADDR_CFG: begin
        next_rdata = {1'b0, update_hold, 1'b0, byte_half_select,
                      value_type_select, channel_select};
      end
      `ECPT_ADDR_ENABLE: begin
        next_rdata = channel_enable;
      end
      `ECPT_ADDR_LDPOL: begin
        next_rdata = pending;
      end
      `ECPT_ADDR_DATA: begin
        next_rdata = pick_byte(sel_word, byte_half_select);
      end
      default: begin
        next_rdata = `ECPT_RST_BYTE;
      end
    endcase
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= `ECPT_RST_BYTE;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end

endmodule

/* File: verification/ecpt_pin_load.sv */
module ecpt_pin_load (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic [7:0] pwm_out,
  output logic      [7:0] seen_high
);
  timeunit 1ns;
  timeprecision 1ps;
  // Marks each output that has ever driven its load high
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      seen_high <= 8'h00;
    else
      seen_high <= seen_high | pwm_out;
  end
endmodule

/* File: verification/ecpt_timer_sva.sv */
module ecpt_timer_sva #(
  parameter CHANNELS = 8
) (
  input wire logic                clock,
  input wire logic                arst_n,
  input wire logic [7:0]          sfr_addr,
  input wire logic [7:0]          sfr_wdata,
  input wire logic                sfr_wr,
  input wire logic                sfr_rd,
  input wire logic [CHANNELS-1:0] count_tick,
  input wire logic [7:0]          sfr_rdata,
  input wire logic [CHANNELS-1:0] pwm_out,
  input wire logic [CHANNELS-1:0] wrap_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]          cfg_q;
  logic [CHANNELS-1:0] en_q;
  logic [2:0]          ch_q;
  assign ch_q = cfg_q[2:0];
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= 8'h00;
      en_q  <= '0;
    end else if (sfr_wr) begin
      if (sfr_addr == 8'hA9)
        cfg_q <= sfr_wdata & 8'h5F;
      if (sfr_addr == 8'hAA)
        en_q <= sfr_wdata[CHANNELS-1:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_rd(logic [7:0] a);
    sfr_rd && sfr_addr == a;
  endsequence
  sequence s_hold_wr;
    sfr_wr && sfr_addr == 8'hAC && cfg_q[6];
  endsequence
  sequence s_clear;
    sfr_wr && sfr_addr == 8'hA9 && sfr_wdata[5];
  endsequence
  a_unmapped_rd: assert property (
    sfr_rd && (sfr_addr < 8'hA9 || sfr_addr > 8'hAC) |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without read");
  a_cfg_read: assert property (s_rd(8'hA9) |=> sfr_rdata == $past(cfg_q))
    else $error("config read wrong");
  a_enable_read: assert property (
    s_rd(8'hAA) |=> sfr_rdata[CHANNELS-1:0] == $past(en_q))
    else $error("enable read wrong");
  a_held_pending: assert property (
    s_hold_wr ##1 s_rd(8'hAB) |=> sfr_rdata[$past(ch_q)])
    else $error("held write not pending");
  a_clear_pending: assert property (
    s_clear ##1 !sfr_wr ##1 s_rd(8'hAB) |=> sfr_rdata == 8'h00)
    else $error("pending survived clear");
  a_off_quiet: assert property (
    ((pwm_out | wrap_pulse) & ~en_q & ~$past(en_q)) == '0)
    else $error("disabled channel active");
  a_wrap_tick: assert property ((wrap_pulse & ~$past(count_tick)) == '0)
    else $error("wrap without tick");
endmodule

bind ecpt_timer ecpt_timer_sva #(.CHANNELS(CHANNELS)) i_ecpt_timer_sva (.clock, .arst_n,
  .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .count_tick, .sfr_rdata, .pwm_out, .wrap_pulse);

/* File: verification/ecpt_timer_tb.sv */
module ecpt_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] timer_mode = 8'h00;
  logic [7:0] count_tick = 8'hFF;
  logic [7:0] sfr_rdata, pwm_out, wrap_pulse, seen_high, rv;
  int         err_count = 0;
  int         checks = 0;
  int         e_m[8];
  int         m_m[8];
  int         per, hi, nw, stall;
  logic       lv;
  always #2.5 clock = ~clock;
  ecpt_timer i_ecpt_timer (.clock, .arst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
    .timer_mode, .count_tick, .sfr_rdata, .pwm_out, .wrap_pulse);
  ecpt_pin_load i_ecpt_pin_load (.clock, .arst_n, .pwm_out, .seen_high);
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // One bus cycle per call, launched and ended at falling edges
  task automatic acc(input logic w, r, input logic [7:0] a, d);
    sfr_wr = w;
    sfr_rd = r;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] a, d);
    acc(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    acc(1'b0, 1'b1, a, 8'h00);
    d = sfr_rdata;
  endtask
  task automatic set_val(input int ch, input logic h, s, input logic [15:0] v);
    wr(8'hA9, {1'b0, h, 2'b01, s, ch[2:0]});
    wr(8'hAC, v[15:8]);
    wr(8'hA9, {1'b0, h, 2'b00, s, ch[2:0]});
    wr(8'hAC, v[7:0]);
  endtask
  // Cycles from one wrap to the next, and how many of them were high
  task automatic meas(input int ch, output int p, output int h);
    int n;
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    n = 0;
    p = 0;
    h = 0;
    while (wrap_pulse[ch] !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    do begin
      @(negedge clock);
      p++;
      h += (pwm_out[ch] === 1'b1);
    end while (wrap_pulse[ch] !== 1'b1 && p < 3000);
    if (n >= 3000 || p >= 3000) begin
      err_count++;
      give_verdict();
    end
  endtask
  // Cycles until the next wrap, counted on from the caller's start point
  task automatic to_wrap(input int ch, input int k0, output int n);
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    n = k0 + 1;
    while (wrap_pulse[ch] !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 3000) begin
      err_count++;
      give_verdict();
    end
  endtask
  initial begin
    void'($urandom(32'hF634D7AC));
    repeat (12) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    for (int a = 8'hA9; a <= 8'hAC; a++) begin
      rd(a[7:0], rv);
      chk("reset value", 8'h00, rv);
    end
    rd(8'h90 + 8'($urandom % 16), rv);
    chk("unmapped", 8'h00, rv);
    $display("test reset done");
    wr(8'hAB, 8'hA5);
    for (int c = 0; c < 8; c++) begin
      e_m[c] = 4 + $urandom % 400;
      m_m[c] = 1 + $urandom % e_m[c];
      set_val(c, 1'b0, 1'b1, 16'(e_m[c]));
      set_val(c, 1'b0, 1'b0, 16'(m_m[c]));
      rd(8'hAC, rv);
      chk("mid low", 16'(m_m[c] % 256), rv);
      wr(8'hA9, 8'h18 | 8'(c));
      rd(8'hAC, rv);
      chk("end high", 16'(e_m[c] / 256), rv);
    end
    wr(8'hAA, 8'hFF);
    rd(8'hAA, rv);
    chk("enable", 8'hFF, rv);
    for (int c = 0; c < 8; c++) begin
      meas(c, per, hi);
      chk("period", 16'(e_m[c] + 1), 16'(per));
      chk("high", 16'(((8'hA5 >> c) & 1) ? m_m[c] : e_m[c] + 1 - m_m[c]), 16'(hi));
    end
    chk("pins", 8'hFF, seen_high);
    $display("test pulse done");
    set_val(2, 1'b1, 1'b1, 16'(e_m[2] + 7));
    rd(8'hAB, rv);
    chk("pending", 8'h04, rv & 8'h04);
    meas(2, per, hi);
    chk("held period", 16'(e_m[2] + 1), 16'(per));
    wr(8'hA9, 8'h0A);
    meas(2, per, hi);
    meas(2, per, hi);
    chk("new period", 16'(e_m[2] + 8), 16'(per));
    rd(8'hAB, rv);
    chk("loaded", 8'h00, rv & 8'h04);
    $display("test hold done");
    wr(8'hAA, 8'hF7);
    repeat (3) acc(1'b0, 1'b0, 8'h00, 8'h00);
    chk("off level", 1'b0, pwm_out[3]);
    set_val(0, 1'b1, 1'b1, 16'(e_m[0] + 3));
    meas(1, per, hi);
    wr(8'hA9, 8'h20);
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    rd(8'hAB, rv);
    chk("clear pending", 8'h00, rv);
    rd(8'hA9, rv);
    chk("clear bit", 8'h00, rv & 8'h20);
    to_wrap(1, 3, nw);
    chk("clear count", 16'(e_m[1] + 2), 16'(nw));
    $display("test clear done");
    timer_mode = 8'h02;
    meas(1, per, hi);
    meas(1, per, hi);
    chk("timer period", 16'(e_m[1] + 1), 16'(per));
    chk("timer level", 16'(pwm_out[1] ? 1 : e_m[1]), 16'(hi));
    lv = pwm_out[1];
    to_wrap(1, 0, nw);
    chk("timer next", 16'(e_m[1] + 1), 16'(nw));
    chk("timer toggle", !lv, pwm_out[1]);
    count_tick = 8'hFD;
    wr(8'hAB, 8'h02);
    stall = 1 + $urandom % 50;
    repeat (stall - 1) acc(1'b0, 1'b0, 8'h00, 8'h00);
    count_tick = 8'hFF;
    to_wrap(1, stall - 1, nw);
    chk("timer clear", 16'(e_m[1] + stall), 16'(nw));
    rd(8'hAB, rv);
    chk("timer no pend", 8'h00, rv & 8'h02);
    $display("test timer done");
    give_verdict();
  end
endmodule
